// file: rtl/flash_id_otp.sv
// command interpreter for identity reads and the one-time security sector
`timescale 1ns/1ps
module flash_id_otp #(
  parameter logic [7:0] MFR_ID   = 8'h5a, // arbitrary identity value
  parameter logic [7:0] DEV_ID   = 8'h13, // arbitrary identity value
  parameter logic [7:0] MEM_TYPE = 8'h30, // arbitrary identity value
  parameter logic [7:0] MEM_CAP  = 8'h14  // arbitrary identity value
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_sclk,
  input  wire logic                     i_cs_n,
  input  wire logic                     i_si,
  input  wire logic                     i_array_busy,
  input  wire logic                     i_deep_pd,
  output logic                          o_so,
  output logic                          o_so_oe_n,
  output logic                          o_otp_mode,
  output logic                          o_otp_lock,
  output logic [7:0]                    o_status,
  output flash_id_pkg::array_req_t      o_array_req,
  output logic                          o_array_go
);
  logic        sclk_rise;      // serial clock rising, selected
  logic        sclk_fall;      // serial clock falling, selected
  logic        cs_rise;        // deselect event
  logic        cs_n;           // chip select level
  logic        shift_bit;      // serialiser output

  flash_id_pkg::phase_t phase_ff;  // phase of current transfer
  logic [7:0]  cmd_ff;             // captured instruction
  logic [23:0] addr_ff;            // captured address
  logic [5:0]  cnt_ff;             // bits received this transfer
  logic [7:0]  data_ff;            // status write data byte
  logic        otp_mode_ff;        // one-time sector mode
  logic        otp_lock_ff;        // permanent lock bit
  logic [7:0]  sr_ff;              // status register
  logic        so_ff;              // serial output bit
  logic        so_oe_n_ff;         // output enable, low drives
  logic        load_ff;            // load serialiser next cycle
  logic [23:0] word_ff;            // identity word to send
  flash_id_pkg::array_req_t req_ff; // request to array control
  logic        go_ff;              // one-cycle request strobe
  logic        sr_mode_ff;         // output is status, not identity

  spi_edge_det u_edge (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_sclk    (i_sclk),
    .i_cs_n    (i_cs_n),
    .o_rise    (sclk_rise),
    .o_fall    (sclk_fall),
    .o_cs_rise (cs_rise),
    .o_cs_n    (cs_n)
  );

  id_shift_out u_shift (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_load    (load_ff),
    .i_word    (word_ff),
    .i_shift   (sclk_fall & (phase_ff == flash_id_pkg::PH_OUT)),
    .i_stop    (cs_rise),
    .o_bit     (shift_bit)
  );

  // decode of the assembled instruction byte
  wire [7:0] cmd_next     = {cmd_ff[6:0], i_si};
  wire       cmd_done     = sclk_rise & (phase_ff == flash_id_pkg::PH_CMD) &
                            (cnt_ff == flash_id_pkg::CMD_BITS - 6'd1);
  wire       addr_done    = sclk_rise & (phase_ff == flash_id_pkg::PH_ADDR) &
                            (cnt_ff == flash_id_pkg::ADDR_END_BITS - 6'd1);
  wire       is_id_cmd    = (cmd_next == flash_id_pkg::CMD_MFR_DEV_ID) |
                            (cmd_next == flash_id_pkg::CMD_READ_IDENT);
  // deep power-down passes only the release instruction
  wire       pd_block     = i_deep_pd & (cmd_next != flash_id_pkg::CMD_RELEASE_PD);
  // identity reads are not decoded during an array cycle
  wire       busy_block   = i_array_busy & is_id_cmd;
  wire       needs_addr   = (cmd_next == flash_id_pkg::CMD_MFR_DEV_ID) |
                            (cmd_next == flash_id_pkg::CMD_SECTOR_ERASE) |
                            (cmd_next == flash_id_pkg::CMD_BLOCK_ERASE) |
                            (cmd_next == flash_id_pkg::CMD_PAGE_PROGRAM);
  wire       imm_out      = (cmd_next == flash_id_pkg::CMD_READ_IDENT) |
                            (cmd_next == flash_id_pkg::CMD_STATUS_READ);

  // identity word: type and capacity follow the manufacturer byte
  wire [23:0] ident_word  = {MFR_ID, MEM_TYPE, MEM_CAP};
  wire [23:0] addr_next   = {addr_ff[22:0], i_si};
  // 90h order flips when the address is 000001h
  wire [23:0] mfr_word    = (addr_next == flash_id_pkg::ADDR_DEV_FIRST) ?
                            {DEV_ID, MFR_ID, DEV_ID} :
                            {MFR_ID, DEV_ID, MFR_ID};

  // the protect position reports the lock while in sector mode
  wire [7:0]  sr_view     = otp_mode_ff ?
                            {otp_lock_ff, sr_ff[6:0]} : sr_ff;
  wire [2:0]  bp_field    = sr_ff[flash_id_pkg::SR_BP_LSB +: 3];

  // security sector window while in sector mode
  wire        in_otp      = otp_mode_ff &
                            (addr_ff >= flash_id_pkg::OTP_ADDR_LO) &
                            (addr_ff <= flash_id_pkg::OTP_ADDR_HI);
  wire        is_prog     = cmd_ff == flash_id_pkg::CMD_PAGE_PROGRAM;
  wire        is_se       = cmd_ff == flash_id_pkg::CMD_SECTOR_ERASE;
  wire        is_oe       = (cmd_ff == flash_id_pkg::CMD_BLOCK_ERASE) |
                            (cmd_ff == flash_id_pkg::CMD_CHIP_ERASE_A) |
                            (cmd_ff == flash_id_pkg::CMD_CHIP_ERASE_B);
  // sector writes need lock clear and all protect bits zero
  wire        otp_ok      = ~otp_lock_ff & (bp_field == 3'b000);
  // other sectors in sector mode need only the lock clear
  wire        other_ok    = ~otp_mode_ff | ~otp_lock_ff;
  // only the sector erase may clear the security sector
  wire        write_ok    = in_otp ? (otp_ok & (is_prog | is_se)) : other_ok;
  wire        addr_cmd_ok = (phase_ff == flash_id_pkg::PH_DATA) | (is_oe & cnt_ff == 6'd8);
  // array requests leave on deselect only, never into a running cycle
  wire        fire_array  = cs_rise & (is_prog | is_se | is_oe) & write_ok &
                            addr_cmd_ok & ~i_array_busy & ~i_deep_pd;
  // single-byte instructions complete only at an 8-bit deselect; they park
  // in the ignore phase after decode, so the phase must not gate them here
  wire        one_byte    = cs_rise & (cnt_ff == flash_id_pkg::CMD_BITS);
  wire        data_done   = cs_rise & (phase_ff == flash_id_pkg::PH_DATA) &
                            (cnt_ff == 6'd16);

  // transfer phase sequencing
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_ff <= flash_id_pkg::PH_CMD;
      cnt_ff   <= 6'd0;
      cmd_ff   <= 8'h00;
      addr_ff  <= 24'h000000;
      data_ff  <= 8'h00;
    end else if (cs_n) begin
      // deselected: back to standby awaiting a command
      phase_ff <= flash_id_pkg::PH_CMD;
      if (!cs_rise) begin
        cnt_ff <= 6'd0;
      end
    end else if (sclk_rise) begin
      if (cnt_ff != 6'd63) begin
        cnt_ff <= cnt_ff + 6'd1;
      end
      unique case (phase_ff)
        flash_id_pkg::PH_CMD: begin
          cmd_ff <= cmd_next;
          if (cmd_done) begin
            if (pd_block | busy_block) begin
              phase_ff <= flash_id_pkg::PH_IGNORE;
            end else if (needs_addr) begin
              phase_ff <= flash_id_pkg::PH_ADDR;
            end else if (imm_out) begin
              phase_ff <= flash_id_pkg::PH_OUT;
            end else if (cmd_next == flash_id_pkg::CMD_STATUS_WRITE) begin
              phase_ff <= flash_id_pkg::PH_DATA;
            end else begin
              phase_ff <= flash_id_pkg::PH_IGNORE;
            end
          end
        end
        flash_id_pkg::PH_ADDR: begin
          addr_ff <= addr_next;
          if (addr_done) begin
            phase_ff <= (cmd_ff == flash_id_pkg::CMD_MFR_DEV_ID) ?
                        flash_id_pkg::PH_OUT : flash_id_pkg::PH_DATA;
          end
        end
        flash_id_pkg::PH_DATA: begin
          data_ff <= {data_ff[6:0], i_si};
        end
        flash_id_pkg::PH_OUT,
        flash_id_pkg::PH_IGNORE: begin
          phase_ff <= phase_ff;
        end
        default: begin
          phase_ff <= flash_id_pkg::PH_IGNORE;
        end
      endcase
    end
  end

  // choose and load the word to send
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      load_ff    <= 1'b0;
      word_ff    <= 24'h000000;
      sr_mode_ff <= 1'b0;
    end else begin
      load_ff <= 1'b0;
      if (cmd_done & ~pd_block & ~busy_block & imm_out) begin
        load_ff    <= 1'b1;
        sr_mode_ff <= cmd_next == flash_id_pkg::CMD_STATUS_READ;
        word_ff    <= ident_word;
      end else if (addr_done & (cmd_ff == flash_id_pkg::CMD_MFR_DEV_ID)) begin
        load_ff    <= 1'b1;
        sr_mode_ff <= 1'b0;
        word_ff    <= mfr_word;
      end
    end
  end

  // serial output driven only on falling edges during output phase
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      so_ff      <= 1'b0;
      so_oe_n_ff <= 1'b1;
    end else if (cs_n) begin
      so_oe_n_ff <= 1'b1;
    end else if (sclk_fall & (phase_ff == flash_id_pkg::PH_OUT)) begin
      // status reads repeat the live view, identity shifts msb first
      so_ff      <= sr_mode_ff ? sr_view[7 - cnt_ff[2:0]] : shift_bit;
      so_oe_n_ff <= 1'b0;
    end
  end

  // sector mode, lock and status register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      otp_mode_ff <= 1'b0;
      otp_lock_ff <= 1'b0;
      sr_ff       <= flash_id_pkg::SR_RESET;
      // power-down freezes mode and lock, whatever was shifted in
    end else if (one_byte & ~i_deep_pd) begin
      if (cmd_ff == flash_id_pkg::CMD_OTP_ENTER) begin
        otp_mode_ff <= 1'b1;
      end else if (cmd_ff == flash_id_pkg::CMD_WRITE_DISABLE) begin
        otp_mode_ff <= 1'b0;
      end
    end else if (data_done & ~i_array_busy & ~i_deep_pd) begin
      if (otp_mode_ff) begin
        // data byte is discarded, lock is set for good
        otp_lock_ff <= 1'b1;
      end else begin
        sr_ff <= data_ff;
      end
    end
  end

  // array request strobe on deselect
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      req_ff <= '0;
      go_ff  <= 1'b0;
    end else begin
      go_ff <= fire_array;
      if (fire_array) begin
        req_ff.prog        <= is_prog;
        req_ff.sec_erase   <= is_se;
        req_ff.other_erase <= is_oe;
        req_ff.otp_area    <= in_otp;
        req_ff.addr        <= addr_ff;
      end
    end
  end

  // registered outputs
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_otp_mode <= 1'b0;
      o_otp_lock <= 1'b0;
      o_status   <= flash_id_pkg::SR_RESET;
    end else begin
      o_otp_mode <= otp_mode_ff;
      o_otp_lock <= otp_lock_ff;
      o_status   <= sr_view;
    end
  end

  assign o_so        = so_ff;
  assign o_so_oe_n   = so_oe_n_ff;
  assign o_array_req = req_ff;
  assign o_array_go  = go_ff;

  // a locked sector never gets a write request
  a_lock_blocks_otp: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    go_ff |-> !(req_ff.otp_area && $past(otp_lock_ff)))
    else $error("write request issued to locked security sector");

  // only sector erase or program reach the security sector
  a_otp_erase_kind: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (go_ff && req_ff.otp_area) |-> !req_ff.other_erase)
    else $error("non-sector erase reached security sector");

  // output released one cycle after deselect
  a_cs_releases: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cs_rise |=> o_so_oe_n)
    else $error("output still driven after deselect");

  // deselect returns to command phase
  a_cs_standby: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cs_n |=> phase_ff == flash_id_pkg::PH_CMD)
    else $error("not in standby after deselect");

  // busy blocks identity decode
  a_busy_ignores: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (cmd_done && busy_block) |=> phase_ff == flash_id_pkg::PH_IGNORE)
    else $error("identity read decoded while busy");

  // power-down blocks the 3Ah entry; the mode flag may not rise in the
  // cycle that follows any power-down cycle
  a_pd_no_entry: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_deep_pd && !otp_mode_ff) |=> !otp_mode_ff)
    else $error("mode entered during power-down");

  // lock never clears once set
  a_lock_sticky: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    otp_lock_ff |=> otp_lock_ff)
    else $error("lock bit cleared");

  // status view shows the lock in sector mode
  a_sr_shows_lock: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    otp_mode_ff |=> o_status[flash_id_pkg::SR_PROTECT_POS] == $past(otp_lock_ff))
    else $error("protect position not showing lock");

  // identity word loaded right after 9Fh
  a_ident_load: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (cmd_done && !pd_block && !busy_block && cmd_next == flash_id_pkg::CMD_READ_IDENT)
    |=> load_ff && word_ff == {MFR_ID, MEM_TYPE, MEM_CAP})
    else $error("identity word not loaded");
endmodule // flash_id_otp

// file: shared/flash_id_pkg.sv
// shared constants and carrier types for the flash identity and one-time sector interpreter
package flash_id_pkg;
  // instruction codes
  localparam logic [7:0] CMD_MFR_DEV_ID     = 8'h90;
  localparam logic [7:0] CMD_READ_IDENT     = 8'h9f;
  localparam logic [7:0] CMD_OTP_ENTER      = 8'h3a;
  localparam logic [7:0] CMD_WRITE_DISABLE  = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ    = 8'h05;
  localparam logic [7:0] CMD_STATUS_WRITE   = 8'h01;
  localparam logic [7:0] CMD_SECTOR_ERASE   = 8'h20;
  localparam logic [7:0] CMD_BLOCK_ERASE    = 8'hd8;
  localparam logic [7:0] CMD_CHIP_ERASE_A   = 8'hc7;
  localparam logic [7:0] CMD_CHIP_ERASE_B   = 8'h60;
  localparam logic [7:0] CMD_PAGE_PROGRAM   = 8'h02;
  localparam logic [7:0] CMD_RELEASE_PD     = 8'hab;
  // address that swaps identity byte order
  localparam logic [23:0] ADDR_DEV_FIRST    = 24'h000001;
  // security sector window
  localparam logic [23:0] OTP_ADDR_LO       = 24'h0ff000;
  localparam logic [23:0] OTP_ADDR_HI       = 24'h0ff0ff;
  // status register layout
  localparam int          SR_PROTECT_POS    = 7;
  localparam int          SR_BP_LSB         = 2;
  localparam logic [7:0]  SR_RESET          = 8'h00;
  localparam logic [7:0]  ARRAY_ERASED      = 8'hff;
  // bit counts of the serial phases
  localparam logic [5:0]  CMD_BITS          = 6'd8;
  localparam logic [5:0]  ADDR_END_BITS     = 6'd32;

  // phases of one selected transfer
  typedef enum logic [2:0] {
    PH_CMD    = 3'b000,
    PH_ADDR   = 3'b001,
    PH_OUT    = 3'b010,
    PH_DATA   = 3'b011,
    PH_IGNORE = 3'b100
  } phase_t;

  // request passed to the array control on chip deselect
  typedef struct packed {
    logic        prog;
    logic        sec_erase;
    logic        other_erase;
    logic        otp_area;
    logic [23:0] addr;
  } array_req_t;
endpackage

// file: rtl/spi_edge_det.sv
// serial clock and chip select edge detector in the system clock domain
`timescale 1ns/1ps
module spi_edge_det (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_sclk,
  input  wire logic i_cs_n,
  output logic      o_rise,
  output logic      o_fall,
  output logic      o_cs_rise,
  output logic      o_cs_n
);
  logic sclk_ff; // previous serial clock level
  logic cs_ff;   // previous chip select level

  // inputs are synchronous, so a single history stage is enough
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_ff <= 1'b0;
      cs_ff   <= 1'b1;
    end else begin
      sclk_ff <= i_sclk;
      cs_ff   <= i_cs_n;
    end
  end

  assign o_rise    = i_sclk & ~sclk_ff & ~i_cs_n;
  assign o_fall    = ~i_sclk & sclk_ff & ~i_cs_n;
  assign o_cs_rise = i_cs_n & ~cs_ff;
  assign o_cs_n    = i_cs_n;
endmodule // spi_edge_det

// file: rtl/id_shift_out.sv
// identity byte serialiser, msb first on falling serial clock edges
`timescale 1ns/1ps
module id_shift_out (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_load,
  input  wire logic [23:0] i_word,
  input  wire logic        i_shift,
  input  wire logic        i_stop,
  output logic             o_bit
);
  logic [23:0] sh_ff; // remaining bits, wraps so reads may run on

  // load first, then rotate left on each falling edge
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sh_ff <= 24'h000000;
    end else if (i_stop) begin
      sh_ff <= 24'h000000;
    end else if (i_load) begin
      sh_ff <= i_word;
    end else if (i_shift) begin
      sh_ff <= {sh_ff[22:0], sh_ff[23]};
    end
  end

  assign o_bit = sh_ff[23];
endmodule // id_shift_out

// file: tb/host_spi_model.sv
// host spi controller model: chip select, serial clock and data in, output capture
`timescale 1ns/1ps
module host_spi_model (
  input  wire logic i_sys_clk,
  input  wire logic i_so,
  input  wire logic i_so_oe_n,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_si
);
  logic drove; // output was enabled at some sample of the last frame

  // idle: deselected, clock low
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
    drove  = 1'b0;
  end

  // wait n system edges, then step just past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  // send ntx bits of tx msb first, then clock in nrd bits
  // five system cycles per half so the edge detector always sees each level
  task automatic xfer(input logic [39:0] tx, input int ntx, input int nrd,
                      output logic [23:0] rx);
    rx     = 24'h000000;
    drove  = 1'b0;
    o_cs_n = 1'b0;
    tick(5);
    for (int i = 0; i < ntx + nrd; i++) begin
      o_sclk = 1'b0;
      if (i < ntx) o_si = tx[39-i];
      else o_si = ~o_si;
      tick(5);
      o_sclk = 1'b1;
      if (i >= ntx) begin
        // a released line shows the inverse, so only driven bits count
        rx = {rx[22:0], (i_so_oe_n === 1'b0) ? i_so : ~i_so};
        if (i_so_oe_n === 1'b0) drove = 1'b1;
      end
      tick(5);
    end
    o_sclk = 1'b0; // clock stands low outside frames
    tick(5);
    o_cs_n = 1'b1;
    tick(8);
  endtask

  // released data line keeps changing so a stale level is never trusted
  always @(posedge i_sys_clk) begin
    if (o_cs_n) o_si <= ~o_si;
  end
endmodule // host_spi_model

// file: tb/test_flash_id_otp.sv
// self-checking bench for the identity read and one-time sector interpreter
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module test_flash_id_otp;
  localparam logic [7:0] MFR = 8'h5a; // arbitrary identity value
  localparam logic [7:0] DEV = 8'h13; // arbitrary identity value
  localparam logic [7:0] TYP = 8'h30; // arbitrary identity value
  localparam logic [7:0] CAP = 8'h14; // arbitrary identity value
  logic                     i_sys_clk, i_rst, i_array_busy, i_deep_pd;
  logic                     sclk, cs_n, si, so, so_oe_n, otp_mode, otp_lock, go;
  logic [7:0]               status;
  flash_id_pkg::array_req_t req;
  logic [23:0]              rx;        // bits read back in the last frame
  int                       miscompares, checked, gos, cycles, n;

  flash_id_otp #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(TYP), .MEM_CAP(CAP))
  flash_id_otp_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_si(si), .i_array_busy(i_array_busy), .i_deep_pd(i_deep_pd), .o_so(so),
    .o_so_oe_n(so_oe_n), .o_otp_mode(otp_mode), .o_otp_lock(otp_lock),
    .o_status(status), .o_array_req(req), .o_array_go(go));

  host_spi_model host_spi_model_inst (.i_sys_clk(i_sys_clk), .i_so(so),
    .i_so_oe_n(so_oe_n), .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si));

  // 50 ns clock
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // count accepted array requests; the pulse stands one cycle only
  always @(posedge i_sys_clk) begin
    if (go === 1'b1) gos++;
  end

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      complete_run();
    end
  end

  // one frame through the host model
  task automatic run(input logic [39:0] tx, input int ntx, input int nrd);
    host_spi_model_inst.xfer(tx, ntx, nrd, rx);
  endtask

  task automatic complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // delivered state straight after reset
  task automatic t_reset;
    `CHK("status", 8'h00, status)
    `CHK("otp mode", 1'b0, otp_mode)
    `CHK("so oe_n", 1'b1, so_oe_n)
  endtask

  // both byte orders of the manufacturer/device read
  task automatic t_mfr_dev;
    run({flash_id_pkg::CMD_MFR_DEV_ID, 24'h000000, 8'h00}, 32, 16);
    `CHK("mfr dev", {MFR, DEV}, rx[15:0])
    run({flash_id_pkg::CMD_MFR_DEV_ID, flash_id_pkg::ADDR_DEV_FIRST, 8'h00}, 32, 16);
    `CHK("dev mfr", {DEV, MFR}, rx[15:0])
  endtask

  // full identification, an abandoned one, then a fresh command
  task automatic t_ident;
    run({flash_id_pkg::CMD_READ_IDENT, 32'h0}, 8, 24);
    `CHK("ident", {MFR, TYP, CAP}, rx)
    run({flash_id_pkg::CMD_READ_IDENT, 32'h0}, 8, 5);
    `CHK("ident part", MFR[7:3], rx[4:0])
    `CHK("oe_n abort", 1'b1, so_oe_n)
    run({flash_id_pkg::CMD_MFR_DEV_ID, 24'h000000, 8'h00}, 32, 16);
    `CHK("after abort", {MFR, DEV}, rx[15:0])
  endtask

  // identity reads refused while busy or powered down
  task automatic t_refused;
    n = gos;
    i_array_busy = 1'b1;
    run({flash_id_pkg::CMD_READ_IDENT, 32'h0}, 8, 24);
    `CHK("busy drive", 1'b0, host_spi_model_inst.drove)
    `CHK("busy go", n, gos)
    i_array_busy = 1'b0;
    i_deep_pd    = 1'b1;
    // the 90h read stands in here, the host keeps 9Fh away in power-down
    run({flash_id_pkg::CMD_MFR_DEV_ID, 24'h000000, 8'h00}, 32, 16);
    `CHK("pd drive", 1'b0, host_spi_model_inst.drove)
    run({flash_id_pkg::CMD_OTP_ENTER, 32'h0}, 8, 0);
    `CHK("pd entry", 1'b0, otp_mode)
    i_deep_pd = 1'b0;
  endtask

  // one-time sector entry, writes, locking and exit
  task automatic t_otp;
    run({flash_id_pkg::CMD_STATUS_WRITE, 8'h00, 24'h0}, 16, 0);
    run({flash_id_pkg::CMD_OTP_ENTER, 32'h0}, 9, 0);
    `CHK("entry 9 bits", 1'b0, otp_mode)
    run({flash_id_pkg::CMD_OTP_ENTER, 32'h0}, 8, 0);
    `CHK("entry", 1'b1, otp_mode)
    n = gos;
    run({flash_id_pkg::CMD_SECTOR_ERASE, flash_id_pkg::OTP_ADDR_LO, 8'h00}, 32, 0);
    `CHK("otp erase go", n + 1, gos)
    `CHK("otp erase req", {4'b0101, flash_id_pkg::OTP_ADDR_LO}, req)
    run({flash_id_pkg::CMD_PAGE_PROGRAM, 24'h0ff100, 8'ha5}, 40, 0);
    `CHK("prog go", n + 2, gos)
    `CHK("prog req", {4'b1000, 24'h0ff100}, req)
    run({flash_id_pkg::CMD_STATUS_WRITE, 8'h00, 24'h0}, 16, 0);
    `CHK("lock", 1'b1, otp_lock)
    `CHK("status lock", 8'h80, status)
    run({flash_id_pkg::CMD_STATUS_READ, 32'h0}, 8, 8);
    `CHK("status read", 8'h80, rx[7:0])
    n = gos;
    run({flash_id_pkg::CMD_SECTOR_ERASE, flash_id_pkg::OTP_ADDR_HI, 8'h00}, 32, 0);
    run({flash_id_pkg::CMD_PAGE_PROGRAM, 24'h000100, 8'h3c}, 40, 0);
    `CHK("locked go", n, gos)
    run({flash_id_pkg::CMD_WRITE_DISABLE, 32'h0}, 8, 0);
    `CHK("exit", 1'b0, otp_mode)
    `CHK("lock sticky", 1'b1, otp_lock)
  endtask

  // reset for 20 cycles, then every scenario in turn
  initial begin
    i_rst        = 1'b1;
    i_array_busy = 1'b0;
    i_deep_pd    = 1'b0;
    repeat (20) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    t_reset();
    t_mfr_dev();
    t_ident();
    t_refused();
    t_otp();
    complete_run();
  end
endmodule // test_flash_id_otp
